// ==== ppom_periph_model.sv ====
// Peripheral side model supplying overrides and input enables
`timescale 1ns/100ps
module ppom_periph_model (
  // Clock
  input wire logic clk_i,
  // Signals produced by the owning peripherals
  output logic match_en_o, match_out_o, grp_o,
  output logic [7:0] mask_o, din_off_o
);
  // Apply a setting at the clock edge lag+1 cycles on, like a slow or prompt peripheral
  task set(input logic en, o, g, input logic [7:0] m, off, input int lag);
    repeat (lag) @(posedge clk_i);
    @(posedge clk_i);
    match_en_o <= en;
    match_out_o <= o;
    grp_o <= g;
    mask_o <= m;
    din_off_o <= off;
  endtask : set
  // Idle with all overrides low
  initial begin
    {match_en_o, match_out_o, grp_o, mask_o, din_off_o} = '0;
  end
endmodule : ppom_periph_model

// ==== ppom_pin_mux.sv ====
// One pin's override selection between register bits and a peripheral
`timescale 1ns/100ps
module ppom_pin_mux (
  // Register bits of this pin
  input wire logic pin_pullup_bit_i,
  input wire logic pin_direction_bit_i,
  input wire logic pin_out_value_bit_i,
  // Shared state
  input wire logic rst_i,
  input wire logic sleep_clamp_i,
  // Peripheral overrides of this pin
  input wire ppom_pkg::ppom_ovr_t ovr_i,
  // Resulting pad control
  output ppom_pkg::ppom_pad_t pad_o
);
  import ppom_pkg::*;

  wire logic pullup_sel;
  wire logic drive_sel;
  wire logic input_sel;

  // Pull-up: override value or register bit, forced off in reset
  assign pullup_sel = ovr_i.pullup_override_en
                    ? ovr_i.pullup_override_val // RQ2
                    : pin_pullup_bit_i; // RQ1
  assign pad_o.pullup_en = pullup_sel & ~rst_i; // RQ15

  // Driver enable: override value or direction bit, tri-state in reset
  assign drive_sel = ovr_i.dir_override_en ? ovr_i.dir_override_val // RQ4
                   : pin_direction_bit_i; // RQ3 RQ20
  assign pad_o.drive_en = drive_sel & ~rst_i; // RQ21

  // Driven value: peripheral value or output data bit
  assign pad_o.drive_val = ovr_i.value_override_en
                         ? ovr_i.value_override_val // RQ5
                         : pin_out_value_bit_i; // RQ6 RQ20

  // Digital input enable: override or sleep clamp state
  assign input_sel = ovr_i.input_en_override_en
                   ? ovr_i.input_en_override_val // RQ9
                   : ~sleep_clamp_i; // RQ8
  assign pad_o.input_en = input_sel; // RQ22

endmodule : ppom_pin_mux

// ==== ppom_pkg.sv ====
// Package for the port A pin override mux: constants and carrier structs
package ppom_pkg;

  // Port geometry
  localparam int PPOM_NPINS = 8;

  // Register offsets on the plain register port
  localparam logic [3:0] PPOM_OFF_OUT_VALUE = 4'h0;
  localparam logic [3:0] PPOM_OFF_DIRECTION = 4'h1;
  localparam logic [3:0] PPOM_OFF_PULLUP = 4'h2;
  localparam logic [3:0] PPOM_OFF_INPUT = 4'h3;

  // Reset values
  localparam logic [7:0] PPOM_RST_OUT_VALUE = 8'h00;
  localparam logic [7:0] PPOM_RST_DIRECTION = 8'h00;
  localparam logic [7:0] PPOM_RST_PULLUP = 8'h00;

  // Fixed pin positions of the port A alternate functions
  localparam int PPOM_PIN_TIMER0_CLK = 4;
  localparam int PPOM_PIN_TIMER0_MATCH_B = 5;
  localparam int PPOM_PIN_CMP_POS = 1;
  localparam int PPOM_PIN_CMP_NEG = 2;

  // Override bundle supplied by a peripheral for one pin
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic dir_override_en;
    logic dir_override_val;
    logic value_override_en;
    logic value_override_val;
    logic toggle_override_en;
    logic input_en_override_en;
    logic input_en_override_val;
  } ppom_ovr_t;

  // Pad control for one pin
  typedef struct packed {
    logic pullup_en;
    logic drive_en;
    logic drive_val;
    logic input_en;
  } ppom_pad_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ppom_bus_t;

endpackage : ppom_pkg

// ==== ppom_port_a.sv ====
// Port A pin override mux with its output, direction and pull-up registers
//
// Function
// RQ1: Pull-up follows register bit without override.
// RQ2: Pull-up follows override value when overridden.
// RQ3: Driver enable follows direction bit normally.
// RQ4: Driver enable follows direction override value.
// RQ5: Value override replaces output data bit.
// RQ6: Without value override, drive data bit.
// RQ7: Toggle override inverts output data bit.
// RQ8: Input enable follows sleep state normally.
// RQ9: Input enable follows override value when overridden.
// RQ10: Peripheral input tapped before the synchroniser.
// RQ11: Peripherals synchronise that input unless clock.
// RQ12: Analog path connects straight to the pad.
// RQ13: Overrides come from the owning peripheral.
// RQ14: Strobes shared per port, overrides per pin.
// RQ15: Pull-ups off while reset is active.
// RQ16: Pin n is change source and channel.
// RQ17: Pin 4 gives timer 0 external clock.
// RQ18: Pin 5 carries timer 0 match B.
// RQ19: Pins 1 and 2 feed comparator inputs.
// RQ20: Direction one drives data, zero is input.
// RQ21: Pins tri-state as soon as reset asserts.
// RQ22: Override selection is purely combinational.
// RQ23: Pins without function tie overrides low.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps
module ppom_port_a (
  // Clock, reset, clock enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Register port
  input wire ppom_pkg::ppom_bus_t bus_i,
  output logic [7:0] rdata_o,
  // Sleep clamp shared across ports
  input wire logic sleep_clamp_i,
  // Pad level after the input Schmitt trigger
  input wire logic [7:0] pad_in_i,
  // Pad control outputs
  output logic [7:0] pad_pullup_en_o,
  output logic [7:0] pad_drive_en_o,
  output logic [7:0] pad_drive_val_o,
  output logic [7:0] pad_input_en_o,
  // Timer 0 match B override from the timer
  input wire logic timer0_match_b_en_i,
  input wire logic timer0_match_b_out_i,
  // Pin-change source enables (per pin) and group enable
  input wire logic [7:0] pin_change_mask_i,
  input wire logic pin_change_group_en_i,
  // Converter digital input disable per channel
  input wire logic [7:0] converter_din_off_i,
  // Digital inputs to peripherals
  output logic [7:0] pin_change_src_o,
  output logic timer0_ext_clock_in_o,
  // Analog pad paths to peripherals
  output logic [7:0] converter_channel_in_o,
  output logic comparator_pos_in_o,
  output logic comparator_neg_in_o
);
  import ppom_pkg::*;

  // Register state
  logic [7:0] out_value_q;
  logic [7:0] out_value_d;
  logic [7:0] direction_q;
  logic [7:0] direction_d;
  logic [7:0] pullup_q;
  logic [7:0] pullup_d;
  logic [7:0] sync1_q;
  logic [7:0] pin_input_bit_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Per-pin override bundles and pad results
  ppom_ovr_t ovr [PPOM_NPINS];
  ppom_pad_t pad [PPOM_NPINS];
  wire logic [7:0] toggle_ovr;
  wire logic [7:0] periph_digital_in;

  // Address decode, strobes shared by all pins of the port
  wire logic wr_out = bus_i.wr & (bus_i.addr == PPOM_OFF_OUT_VALUE); // RQ14
  wire logic wr_dir = bus_i.wr & (bus_i.addr == PPOM_OFF_DIRECTION);
  wire logic wr_pu = bus_i.wr & (bus_i.addr == PPOM_OFF_PULLUP);
  wire logic wr_tgl = bus_i.wr & (bus_i.addr == PPOM_OFF_INPUT);

  // Toggle requests from peripherals, one per pin
  genvar g;
  generate
    for (g = 0; g < PPOM_NPINS; g++) begin : g_tgl
      assign toggle_ovr[g] = ovr[g].toggle_override_en;
    end
  endgenerate

  // Next register values; a peripheral toggle inverts the data bit
  assign out_value_d = (wr_out ? bus_i.wdata : out_value_q)
                     ^ (wr_tgl ? bus_i.wdata : 8'h00)
                     ^ toggle_ovr; // RQ7
  assign direction_d = wr_dir ? bus_i.wdata : direction_q;
  assign pullup_d = wr_pu ? bus_i.wdata : pullup_q;

  // Read mux; unmapped offsets read zero
  assign rdata_d =
    (bus_i.addr == PPOM_OFF_OUT_VALUE) ? out_value_q :
    (bus_i.addr == PPOM_OFF_DIRECTION) ? direction_q :
    (bus_i.addr == PPOM_OFF_PULLUP) ? pullup_q :
    (bus_i.addr == PPOM_OFF_INPUT) ? pin_input_bit_q : 8'h00;

  // Port registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      out_value_q <= PPOM_RST_OUT_VALUE;
      direction_q <= PPOM_RST_DIRECTION;
      pullup_q <= PPOM_RST_PULLUP;
    end else if (clk_en_i) begin
      out_value_q <= out_value_d;
      direction_q <= direction_d;
      pullup_q <= pullup_d;
    end
  end

  // Port read synchroniser, two flops on the gated digital input
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync1_q <= 8'h00;
      pin_input_bit_q <= 8'h00;
    end else if (clk_en_i) begin
      sync1_q <= periph_digital_in;
      pin_input_bit_q <= sync1_q;
    end
  end

  // Read data register, valid the cycle after the read strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (clk_en_i) begin
      rdata_q <= bus_i.rd ? rdata_d : 8'h00;
    end
  end
  assign rdata_o = rdata_q;

  // Override sources per pin: pin-change and converter input enables, timer 0 match B value on pin 5
  generate
    for (g = 0; g < PPOM_NPINS; g++) begin : g_pin
      wire logic pc_on = pin_change_mask_i[g] & pin_change_group_en_i;
      always_comb begin
        ovr[g] = '0; // RQ23
        ovr[g].input_en_override_en = pc_on | converter_din_off_i[g];
        ovr[g].input_en_override_val = pc_on;
        if (g == PPOM_PIN_TIMER0_MATCH_B) begin
          ovr[g].value_override_en = timer0_match_b_en_i; // RQ18
          ovr[g].value_override_val = timer0_match_b_out_i; // RQ18
        end
      end

      ppom_pin_mux u_mux (
        .pin_pullup_bit_i(pullup_q[g]),
        .pin_direction_bit_i(direction_q[g]),
        .pin_out_value_bit_i(out_value_q[g]),
        .rst_i(rst_i),
        .sleep_clamp_i(sleep_clamp_i),
        .ovr_i(ovr[g]), // RQ14
        .pad_o(pad[g])
      );

      // Pad control outputs, combinational from the mux
      assign pad_pullup_en_o[g] = pad[g].pullup_en;
      assign pad_drive_en_o[g] = pad[g].drive_en;
      assign pad_drive_val_o[g] = pad[g].drive_val;
      assign pad_input_en_o[g] = pad[g].input_en;

      // Digital input after the Schmitt trigger, clamped when disabled
      assign periph_digital_in[g] = pad_in_i[g] & pad[g].input_en; // RQ10
      assign pin_change_src_o[g] = periph_digital_in[g]; // RQ16 RQ11
      assign converter_channel_in_o[g] = pad_in_i[g]; // RQ12 RQ16
    end
  endgenerate

  // Fixed alternate function taps
  assign timer0_ext_clock_in_o =
    periph_digital_in[PPOM_PIN_TIMER0_CLK]; // RQ17
  assign comparator_pos_in_o = pad_in_i[PPOM_PIN_CMP_POS]; // RQ19
  assign comparator_neg_in_o = pad_in_i[PPOM_PIN_CMP_NEG]; // RQ19

endmodule : ppom_port_a

// ==== ppom_port_a_props.sv ====
// Assertions on port A pad control and peripheral paths
`timescale 1ns/100ps
module ppom_port_a_props (
  // Clock, reset and register port
  input wire logic core_clk_i, input wire logic rst_i,
  input wire logic clk_en_i, input wire ppom_pkg::ppom_bus_t bus_i,
  input wire logic [7:0] rdata_o, input wire logic sleep_clamp_i,
  // Pads
  input wire logic [7:0] pad_in_i, input wire logic [7:0] pad_pullup_en_o,
  input wire logic [7:0] pad_drive_en_o,
  input wire logic [7:0] pad_drive_val_o,
  input wire logic [7:0] pad_input_en_o,
  // Peripheral side
  input wire logic timer0_match_b_en_i, input wire logic timer0_match_b_out_i,
  input wire logic [7:0] pin_change_mask_i,
  input wire logic pin_change_group_en_i,
  input wire logic [7:0] converter_din_off_i,
  input wire logic [7:0] pin_change_src_o,
  input wire logic timer0_ext_clock_in_o,
  input wire logic [7:0] converter_channel_in_o,
  input wire logic comparator_pos_in_o, input wire logic comparator_neg_in_o
);
  import ppom_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  // Writes taken in this cycle, pin-change forced inputs
  wire wr_pu = clk_en_i && bus_i.wr && bus_i.addr == PPOM_OFF_PULLUP;
  wire wr_dd = clk_en_i && bus_i.wr && bus_i.addr == PPOM_OFF_DIRECTION;
  wire [7:0] pc_on = pin_change_mask_i & {8{pin_change_group_en_i}};
  AST_RST: assert property (
    rst_i |-> pad_pullup_en_o == 8'h00 && pad_drive_en_o == 8'h00)
    else $error("pads not released in reset");
  AST_PU_WR: assert property (
    disable iff (rst_i) wr_pu |=> pad_pullup_en_o == $past(bus_i.wdata))
    else $error("pull-up not from register");
  AST_DIR_WR: assert property (
    disable iff (rst_i) wr_dd |=> pad_drive_en_o == $past(bus_i.wdata))
    else $error("driver enable not from register");
  AST_VAL_OVR: assert property (
    disable iff (rst_i) pad_drive_en_o[5] && timer0_match_b_en_i
    |-> pad_drive_val_o[5] == timer0_match_b_out_i)
    else $error("match output not on pin");
  AST_DIN: assert property (
    disable iff (rst_i)
    pad_input_en_o == (pc_on | (~converter_din_off_i & {8{!sleep_clamp_i}})))
    else $error("input enable wrong");
  AST_DI: assert property (
    disable iff (rst_i) pin_change_src_o == (pad_in_i & pad_input_en_o)
    && timer0_ext_clock_in_o == pin_change_src_o[4])
    else $error("digital input tap wrong");
  AST_AIO: assert property (
    disable iff (rst_i) converter_channel_in_o == pad_in_i
    && comparator_pos_in_o == pad_in_i[1]
    && comparator_neg_in_o == pad_in_i[2])
    else $error("analog path wrong");
  AST_RD0: assert property (
    disable iff (rst_i) clk_en_i && !bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data outside read slot");
endmodule : ppom_port_a_props
bind ppom_port_a ppom_port_a_props u_props (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .sleep_clamp_i(sleep_clamp_i),
  .pad_in_i(pad_in_i), .pad_pullup_en_o(pad_pullup_en_o),
  .pad_drive_en_o(pad_drive_en_o), .pad_drive_val_o(pad_drive_val_o),
  .pad_input_en_o(pad_input_en_o),
  .timer0_match_b_en_i(timer0_match_b_en_i),
  .timer0_match_b_out_i(timer0_match_b_out_i),
  .pin_change_mask_i(pin_change_mask_i),
  .pin_change_group_en_i(pin_change_group_en_i),
  .converter_din_off_i(converter_din_off_i),
  .pin_change_src_o(pin_change_src_o),
  .timer0_ext_clock_in_o(timer0_ext_clock_in_o),
  .converter_channel_in_o(converter_channel_in_o),
  .comparator_pos_in_o(comparator_pos_in_o),
  .comparator_neg_in_o(comparator_neg_in_o));

// ==== ppom_port_a_tb.sv ====
// Testbench of the port A pin override mux
`timescale 1ns/100ps
module ppom_port_a_tb;
  import ppom_pkg::*;
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, sleep = 1'b0;
  ppom_bus_t bus = '0;
  logic [7:0] pad_in = 8'h00, rdata, pu, de, dv, ie, pcs, conv, mask, doff;
  logic t0, cpos, cneg, m_en, m_out, grp;
  int bad_count = 0, n_tests = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  ppom_periph_model per (.clk_i(clk), .match_en_o(m_en), .match_out_o(m_out),
    .grp_o(grp), .mask_o(mask), .din_off_o(doff));
  ppom_port_a uut (.core_clk_i(clk), .rst_i(rst), .clk_en_i(clk_en),
    .bus_i(bus), .rdata_o(rdata), .sleep_clamp_i(sleep), .pad_in_i(pad_in),
    .pad_pullup_en_o(pu), .pad_drive_en_o(de), .pad_drive_val_o(dv),
    .pad_input_en_o(ie), .timer0_match_b_en_i(m_en),
    .timer0_match_b_out_i(m_out), .pin_change_mask_i(mask),
    .pin_change_group_en_i(grp), .converter_din_off_i(doff),
    .pin_change_src_o(pcs), .timer0_ext_clock_in_o(t0),
    .converter_channel_in_o(conv), .comparator_pos_in_o(cpos),
    .comparator_neg_in_o(cneg));
  // Compare one byte
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One-cycle register write
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  // One-cycle register read, data checked in the following cycle
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  // Verdict
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // Watchdog
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end
  // Test sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr(PPOM_OFF_PULLUP, 8'h3c);
    #1 chk(pu, 8'h3c);
    wr(PPOM_OFF_DIRECTION, 8'h21);
    #1 chk(de, 8'h21);
    wr(PPOM_OFF_OUT_VALUE, 8'ha5);
    #1 chk(dv & de, 8'h21);
    rd(PPOM_OFF_OUT_VALUE, 8'ha5);
    rd(PPOM_OFF_DIRECTION, 8'h21);
    rd(4'h7, 8'h00);
    wr(PPOM_OFF_INPUT, 8'h0f);
    rd(PPOM_OFF_OUT_VALUE, 8'haa);
    per.set(1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 2);
    #1 chk(dv & 8'h20, 8'h00);
    per.set(1'b0, 1'b0, 1'b1, 8'h03, 8'h0c, 0);
    #1 chk(dv & 8'h20, 8'h20);
    @(posedge clk);
    pad_in <= 8'hff;
    sleep <= 1'b1;
    #1 chk(ie, 8'h03);
    chk(pcs, 8'h03);
    @(posedge clk);
    sleep <= 1'b0;
    #1 chk(pcs, 8'hf3);
    chk({7'h00, t0}, 8'h01);
    chk({6'h00, cneg, cpos}, 8'h03);
    chk(conv, 8'hff);
    repeat (2) @(posedge clk);
    rd(PPOM_OFF_INPUT, 8'hf3);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(PPOM_OFF_DIRECTION, 8'h00);
    clk_en <= 1'b1;
    #1 chk(de, 8'h21);
    @(posedge clk);
    rst <= 1'b1;
    #1 chk(pu, 8'h00);
    chk(de, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    rd(PPOM_OFF_PULLUP, 8'h00);
    tally_and_finish;
  end
endmodule : ppom_port_a_tb
